// ### logic/display_timing_and_palette_port.sv
// Display timing generator, colour look-up table port and AXI4-Lite register slave
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Frame period set by 11-bit total height
// - Line period set by 11-bit total width
// - Hold 8-bit leading inactive line count
// - Hold 8-bit leading inactive pixel clock count
// - Hsync active for programmed width in clocks
// - Hsync toggles only when enabled; width >= 1
// - Hsync starts delay clocks after blanking start
// - Vsync active for programmed width in lines
// - Vsync toggles only when enabled; width >= 1
// - Vsync starts delay lines after blanking start
// - First displayed line after programmed blanking lines
// - First displayed pixel after programmed blanking clocks
// - Palette applied only while table enable set
// - Busy reads one during palette access
// - Read trigger with access enabled reads entry
// - Rising trigger reads entry into read data
// - Access enable blocks display use of table
// - 8-bit address selects one of 256 entries
// - Word or high byte write writes entry
// - Low byte write only updates low bits
// - Last written data times panel power output
module display_timing_and_palette_port
  import disp_timing_pkg::*;
#(
  parameter int PALETTE_DEPTH = 256
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // Pixel clock, sampled on the system clock
  input  wire logic        i_pixel_clock,
  input  wire logic [7:0]  i_pixel_index,
  output logic             o_panel_clock,
  output logic             o_hsync,
  output logic             o_vsync,
  output logic             o_display_enable,
  output logic             o_active_area,
  output logic [15:0]      o_pixel_color,
  output logic             o_panel_power,
  // AXI4-Lite slave
  input  wire logic [7:0]  i_axi_awaddr,
  input  wire logic        i_axi_awvalid,
  output logic             o_axi_awready,
  input  wire logic [31:0] i_axi_wdata,
  input  wire logic [3:0]  i_axi_wstrb,
  input  wire logic        i_axi_wvalid,
  output logic             o_axi_wready,
  output logic [1:0]       o_axi_bresp,
  output logic             o_axi_bvalid,
  input  wire logic        i_axi_bready,
  input  wire logic [7:0]  i_axi_araddr,
  input  wire logic        i_axi_arvalid,
  output logic             o_axi_arready,
  output logic [31:0]      o_axi_rdata,
  output logic [1:0]       o_axi_rresp,
  output logic             o_axi_rvalid,
  input  wire logic        i_axi_rready
);

  // Software registers
  logic [15:0] frame_total_height;
  logic [15:0] frame_total_width;
  logic [15:0] active_area_offsets;
  logic [15:0] horizontal_sync_control;
  logic [15:0] vertical_sync_control;
  logic [15:0] blanking_control;
  logic [15:0] palette_control;
  logic [15:0] palette_write_data;
  logic [15:0] palette_read_data;
  logic [15:0] display_control;

  // Bus bookkeeping
  logic        aw_full;
  logic        w_full;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        reg_hit;

  // Palette state
  logic [15:0] palette_mem [PALETTE_DEPTH];
  pal_state_t  pal_state;
  logic        trigger_prev;
  logic        pal_busy;
  logic        start_read;
  logic        start_write;

  // Timing state
  timing_cfg_t cfg;
  logic        pclk_meta;
  logic        pclk_sync;
  logic        pclk_last;
  logic        pixel_tick;
  logic [10:0] h_count;
  logic [10:0] v_count;
  logic        line_end;
  logic [8:0]  hsync_end;
  logic [8:0]  vsync_end;
  logic [15:0] power_count;

  // Merge byte lanes of a 16-bit register
  function automatic logic [15:0] merge_bytes(input logic [15:0] old_val,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
    logic [15:0] res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge_bytes

  // AXI4-Lite slave

  // Address and data taken independently
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_axi_awready <= 1'b0;
      aw_full       <= 1'b0;
      aw_addr       <= 8'h00;
    end else begin
      o_axi_awready <= ~o_axi_awready & i_axi_awvalid & ~aw_full & ~o_axi_bvalid;
      if (i_axi_awvalid && o_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= i_axi_awaddr;
      end else if (do_write) begin
        aw_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_axi_wready <= 1'b0;
      w_full       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
    end else begin
      o_axi_wready <= ~o_axi_wready & i_axi_wvalid & ~w_full & ~o_axi_bvalid;
      if (i_axi_wvalid && o_axi_wready) begin
        w_full <= 1'b1;
        w_data <= i_axi_wdata;
        w_strb <= i_axi_wstrb;
      end else if (do_write) begin
        w_full <= 1'b0;
      end
    end
  end

  assign do_write = aw_full & w_full & ~o_axi_bvalid;

  // Writable offsets; writes to read data are ignored
  always_comb begin
    case (aw_addr)
      OFS_FRAME_TOTAL_HEIGHT, OFS_FRAME_TOTAL_WIDTH, OFS_ACTIVE_AREA_OFFSETS,
      OFS_HSYNC_CONTROL, OFS_VSYNC_CONTROL, OFS_BLANKING_CONTROL,
      OFS_PALETTE_CONTROL, OFS_PALETTE_WRITE_DATA, OFS_PALETTE_READ_DATA,
      OFS_DISPLAY_CONTROL: reg_hit = 1'b1;
      default:             reg_hit = 1'b0;
    endcase
  end

  // Response raised on the same edge as the update
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_axi_bvalid <= 1'b0;
      o_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      o_axi_bvalid <= 1'b1;
      o_axi_bresp  <= reg_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (i_axi_bready) begin
      o_axi_bvalid <= 1'b0;
    end
  end

  // Plain configuration registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      frame_total_height      <= REG_RESET;
      frame_total_width       <= REG_RESET;
      active_area_offsets     <= REG_RESET;
      horizontal_sync_control <= REG_RESET;
      vertical_sync_control   <= REG_RESET;
      blanking_control        <= REG_RESET;
      display_control         <= REG_RESET;
    end else if (do_write) begin
      case (aw_addr)
        OFS_FRAME_TOTAL_HEIGHT:
          frame_total_height <= merge_bytes(frame_total_height, w_data, w_strb) & TOTAL_MASK;
        OFS_FRAME_TOTAL_WIDTH:
          frame_total_width <= merge_bytes(frame_total_width, w_data, w_strb) & TOTAL_MASK;
        OFS_ACTIVE_AREA_OFFSETS:
          active_area_offsets <= merge_bytes(active_area_offsets, w_data, w_strb);
        OFS_HSYNC_CONTROL:
          horizontal_sync_control <= merge_bytes(horizontal_sync_control, w_data, w_strb);
        OFS_VSYNC_CONTROL:
          vertical_sync_control <= merge_bytes(vertical_sync_control, w_data, w_strb);
        OFS_BLANKING_CONTROL:
          blanking_control <= merge_bytes(blanking_control, w_data, w_strb);
        OFS_DISPLAY_CONTROL:
          display_control <= merge_bytes(display_control, w_data, w_strb)
                             & DISPLAY_CONTROL_MASK;
        default: ;
      endcase
    end
  end

  // Trigger bit holds as written until software clears it
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      palette_control <= REG_RESET;
    end else if (do_write && aw_addr == OFS_PALETTE_CONTROL) begin
      palette_control <= merge_bytes(palette_control, w_data, w_strb)
                         & PALETTE_CONTROL_MASK;
    end
  end

  // Write data; a low byte alone never reaches the table
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      palette_write_data <= REG_RESET;
    end else if (do_write && aw_addr == OFS_PALETTE_WRITE_DATA && !pal_busy) begin
      palette_write_data <= merge_bytes(palette_write_data, w_data, w_strb);
    end
  end

  // Read data follows the address by one cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_axi_arready <= 1'b0;
      o_axi_rvalid  <= 1'b0;
      o_axi_rdata   <= 32'h0000_0000;
      o_axi_rresp   <= RESP_OKAY;
    end else begin
      o_axi_arready <= ~o_axi_arready & i_axi_arvalid & ~o_axi_rvalid;
      if (i_axi_arvalid && o_axi_arready) begin
        o_axi_rvalid <= 1'b1;
        o_axi_rresp  <= RESP_OKAY;
        case (i_axi_araddr)
          OFS_FRAME_TOTAL_HEIGHT:  o_axi_rdata <= {16'h0000, frame_total_height};
          OFS_FRAME_TOTAL_WIDTH:   o_axi_rdata <= {16'h0000, frame_total_width};
          OFS_ACTIVE_AREA_OFFSETS: o_axi_rdata <= {16'h0000, active_area_offsets};
          OFS_HSYNC_CONTROL:       o_axi_rdata <= {16'h0000, horizontal_sync_control};
          OFS_VSYNC_CONTROL:       o_axi_rdata <= {16'h0000, vertical_sync_control};
          OFS_BLANKING_CONTROL:    o_axi_rdata <= {16'h0000, blanking_control};
          OFS_PALETTE_CONTROL:
            o_axi_rdata <= {16'h0000, palette_control[15], pal_busy,
                            palette_control[13:0]};
          OFS_PALETTE_WRITE_DATA:  o_axi_rdata <= {16'h0000, palette_write_data};
          OFS_PALETTE_READ_DATA:   o_axi_rdata <= {16'h0000, palette_read_data};
          OFS_DISPLAY_CONTROL:     o_axi_rdata <= {16'h0000, display_control};
          default: begin
            o_axi_rdata <= 32'h0000_0000;
            o_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (i_axi_rready) begin
        o_axi_rvalid <= 1'b0;
      end
    end
  end

  // Palette access port

  assign pal_busy    = (pal_state != PAL_IDLE);
  // Trigger edge counts only with access on and port idle
  assign start_read  = palette_control[POS_PAL_TRIGGER] & ~trigger_prev
                       & palette_control[POS_PAL_ACCESS] & ~pal_busy;
  assign start_write = do_write & (aw_addr == OFS_PALETTE_WRITE_DATA) & w_strb[1]
                       & palette_control[POS_PAL_ACCESS] & ~pal_busy;

  // Edge history of the read trigger
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      trigger_prev <= 1'b0;
    end else if (!pal_busy) begin
      trigger_prev <= palette_control[POS_PAL_TRIGGER];
    end
  end

  // Access sequencer; busy lasts one cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pal_state <= PAL_IDLE;
    end else begin
      case (pal_state)
        PAL_IDLE: begin
          if (start_read) begin
            pal_state <= PAL_READ;
          end else if (start_write) begin
            pal_state <= PAL_WRITE;
          end
        end
        PAL_READ:  pal_state <= PAL_IDLE;
        PAL_WRITE: pal_state <= PAL_IDLE;
        default:   pal_state <= PAL_IDLE;
      endcase
    end
  end

  // Table write once the data register has settled
  always_ff @(posedge i_sys_clk) begin
    if (pal_state == PAL_WRITE) begin
      palette_mem[palette_control[7:0]] <= palette_write_data;
    end
  end

  // Read data captured from the table at the current address
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      palette_read_data <= REG_RESET;
    end else if (pal_state == PAL_READ) begin
      palette_read_data <= palette_mem[palette_control[7:0]];
    end
  end

  // Raw index passes through while software owns the table
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_pixel_color <= 16'h0000;
    end else if (palette_control[POS_PAL_ENABLE] && !palette_control[POS_PAL_ACCESS]) begin
      o_pixel_color <= palette_mem[i_pixel_index];
    end else begin
      o_pixel_color <= {8'h00, i_pixel_index};
    end
  end

  // Timing generator

  assign cfg = '{
    total_height:            frame_total_height[TOTAL_MSB:0],
    total_width:             frame_total_width[TOTAL_MSB:0],
    leading_inactive_lines:  active_area_offsets[15:8],
    leading_inactive_pixels: active_area_offsets[7:0],
    hsync_width:             horizontal_sync_control[15:8],
    hsync_delay:             horizontal_sync_control[7:0],
    vsync_width:             vertical_sync_control[15:8],
    vsync_delay:             vertical_sync_control[7:0],
    vblank_to_first_line:    blanking_control[15:8],
    hblank_to_first_pixel:   blanking_control[7:0],
    hsync_output_enable:     display_control[POS_HSYNC_OE],
    vsync_output_enable:     display_control[POS_VSYNC_OE]
  };

  // Two-stage synchroniser, third stage for edges
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pclk_meta <= 1'b0;
      pclk_sync <= 1'b0;
      pclk_last <= 1'b0;
    end else begin
      pclk_meta <= i_pixel_clock;
      pclk_sync <= pclk_meta;
      pclk_last <= pclk_sync;
    end
  end

  assign pixel_tick = pclk_sync & ~pclk_last;
  // Wrap at total minus one; a shrunk total also wraps at once
  assign line_end   = (h_count >= cfg.total_width - 11'h001) | (cfg.total_width == 11'h000);
  assign hsync_end  = {1'b0, cfg.hsync_delay} + {1'b0, cfg.hsync_width};
  assign vsync_end  = {1'b0, cfg.vsync_delay} + {1'b0, cfg.vsync_width};

  // Pixel and line counters; 0 starts blanking
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      h_count <= 11'h000;
      v_count <= 11'h000;
    end else if (pixel_tick) begin
      if (line_end) begin
        h_count <= 11'h000;
        if (v_count >= cfg.total_height - 11'h001 || cfg.total_height == 11'h000) begin
          v_count <= 11'h000;
        end else begin
          v_count <= v_count + 11'h001;
        end
      end else begin
        h_count <= h_count + 11'h001;
      end
    end
  end

  // Sync, blanking and active outputs, all registered
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_hsync          <= 1'b0;
      o_vsync          <= 1'b0;
      o_display_enable <= 1'b0;
      o_active_area    <= 1'b0;
      o_panel_clock    <= 1'b0;
    end else begin
      o_panel_clock    <= pclk_sync;
      o_hsync          <= cfg.hsync_output_enable
                          && {1'b0, h_count} >= {1'b0, cfg.hsync_delay}
                          && {1'b0, h_count} < {3'b000, hsync_end};
      o_vsync          <= cfg.vsync_output_enable
                          && {1'b0, v_count} >= {1'b0, cfg.vsync_delay}
                          && {1'b0, v_count} < {3'b000, vsync_end};
      o_display_enable <= v_count >= {3'b000, cfg.vblank_to_first_line}
                          && h_count >= {3'b000, cfg.hblank_to_first_pixel};
      // Panel data width changes pixels per clock, not this clock count
      o_active_area    <= v_count >= {3'b000, cfg.leading_inactive_lines}
                          && h_count >= {3'b000, cfg.leading_inactive_pixels};
    end
  end

  // Power waits as many lines as the write data word holds
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_panel_power <= 1'b0;
      power_count   <= 16'h0000;
    end else if (display_control[POS_POWER_REQ] == o_panel_power) begin
      power_count <= 16'h0000;
    end else if (power_count >= palette_write_data) begin
      o_panel_power <= display_control[POS_POWER_REQ];
      power_count   <= 16'h0000;
    end else if (pixel_tick && line_end) begin
      power_count <= power_count + 16'h0001;
    end
  end

endmodule : display_timing_and_palette_port

`default_nettype wire

// ### common/disp_timing_pkg.sv
// Constants and types for the display timing block
package disp_timing_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFS_FRAME_TOTAL_HEIGHT  = 8'h00;
  localparam logic [7:0] OFS_FRAME_TOTAL_WIDTH   = 8'h04;
  localparam logic [7:0] OFS_ACTIVE_AREA_OFFSETS = 8'h08;
  localparam logic [7:0] OFS_HSYNC_CONTROL       = 8'h0C;
  localparam logic [7:0] OFS_VSYNC_CONTROL       = 8'h10;
  localparam logic [7:0] OFS_BLANKING_CONTROL    = 8'h14;
  localparam logic [7:0] OFS_PALETTE_CONTROL     = 8'h18;
  localparam logic [7:0] OFS_PALETTE_WRITE_DATA  = 8'h1C;
  localparam logic [7:0] OFS_PALETTE_READ_DATA   = 8'h20;
  localparam logic [7:0] OFS_DISPLAY_CONTROL     = 8'h24;

  // Value of every register after reset
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Field positions
  localparam int TOTAL_MSB        = 10;
  localparam int POS_PAL_ENABLE   = 15;
  localparam int POS_PAL_BUSY     = 14;
  localparam int POS_PAL_TRIGGER  = 9;
  localparam int POS_PAL_ACCESS   = 8;
  localparam int POS_HSYNC_OE     = 0;
  localparam int POS_VSYNC_OE     = 1;
  localparam int POS_POWER_REQ    = 2;
  localparam int POS_PANEL_TYPE   = 4;
  localparam int POS_DATA_WIDTH   = 14;

  // Masks of implemented bits
  localparam logic [15:0] DISPLAY_CONTROL_MASK = 16'hC077;
  localparam logic [15:0] PALETTE_CONTROL_MASK = 16'h83FF;
  localparam logic [15:0] TOTAL_MASK           = 16'h07FF;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Palette access sequencer states
  typedef enum logic [2:0] {
    PAL_IDLE  = 3'b001,
    PAL_READ  = 3'b010,
    PAL_WRITE = 3'b100
  } pal_state_t;

  // Timing configuration seen by the counters
  typedef struct packed {
    logic [10:0] total_height;
    logic [10:0] total_width;
    logic [7:0]  leading_inactive_lines;
    logic [7:0]  leading_inactive_pixels;
    logic [7:0]  hsync_width;
    logic [7:0]  hsync_delay;
    logic [7:0]  vsync_width;
    logic [7:0]  vsync_delay;
    logic [7:0]  vblank_to_first_line;
    logic [7:0]  hblank_to_first_pixel;
    logic        hsync_output_enable;
    logic        vsync_output_enable;
  } timing_cfg_t;

endpackage : disp_timing_pkg

// ### bench/display_timing_checker.sv
// Port-level assertions for the display timing block
`timescale 1ns/1ps
`default_nettype none
module display_timing_checker
  import disp_timing_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        i_pixel_clock,
  input wire logic        o_panel_clock,
  input wire logic        o_hsync,
  input wire logic        o_vsync,
  input wire logic        o_panel_power,
  input wire logic        i_axi_awvalid,
  input wire logic        o_axi_awready,
  input wire logic        i_axi_wvalid,
  input wire logic        o_axi_wready,
  input wire logic        o_axi_bvalid,
  input wire logic        i_axi_bready,
  input wire logic        i_axi_arvalid,
  input wire logic        o_axi_arready,
  input wire logic [31:0] o_axi_rdata,
  input wire logic [1:0]  o_axi_rresp,
  input wire logic        o_axi_rvalid,
  input wire logic        i_axi_rready
);
  logic [2:0] age;

  // Cycles since reset; lag check waits for the sync chain
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  bvalid_hold_a: assert property (o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid)
    else $error("bvalid dropped");
  rvalid_hold_a: assert property (o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata))
    else $error("rvalid dropped");
  awready_pulse_a: assert property (o_axi_awready |=> !o_axi_awready)
    else $error("awready held");
  wready_pulse_a: assert property (o_axi_wready |=> !o_axi_wready)
    else $error("wready held");
  arready_pulse_a: assert property (o_axi_arready |=> !o_axi_arready)
    else $error("arready held");
  read_answer_a: assert property (o_axi_arready && i_axi_arvalid |=> o_axi_rvalid)
    else $error("read data late");
  write_answer_a: assert property (o_axi_awready && o_axi_wready && i_axi_awvalid && i_axi_wvalid
    |-> ##[1:4] o_axi_bvalid) else $error("write response late");
  rdata_upper_a: assert property (o_axi_rvalid |-> o_axi_rdata[31:16] == 16'h0000)
    else $error("rdata high bits");
  err_data_a: assert property (o_axi_rvalid && o_axi_rresp == RESP_SLVERR |-> o_axi_rdata == 32'h0)
    else $error("error with data");
  pclk_delay_a: assert property (age == 3'h7 |-> o_panel_clock == $past(i_pixel_clock, 3))
    else $error("panel clock lag");

  hsync_seen_c: cover property ($rose(o_hsync));
  vsync_seen_c: cover property ($rose(o_vsync));
  power_seen_c: cover property ($rose(o_panel_power));
  slverr_seen_c: cover property (o_axi_rvalid && o_axi_rresp == RESP_SLVERR);
endmodule : display_timing_checker
`default_nettype wire

// ### bench/panel_model.sv
// Panel side model that supplies the pixel clock
`timescale 1ns/1ps
`default_nettype none
module panel_model (
  input  wire logic i_run,
  output logic      o_pixel_clock
);
  // Idles low while i_run is low; odd offset keeps edges off the system clock
  initial begin
    o_pixel_clock = 1'h0;
    #1.3;
    forever begin
      #32;
      o_pixel_clock = i_run ? !o_pixel_clock : 1'h0;
    end
  end
endmodule : panel_model
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the display timing and palette block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import disp_timing_pkg::*;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        run = 1'h0;
  logic        pclk, pc, hs, vs, de, aa, pwr, awready, wready, bvalid, arready, rvalid, seen;
  logic [7:0]  idx = 8'h00, awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h1, arvalid = 1'h0, rready = 1'h1;
  logic [1:0]  bresp, rresp;
  logic [15:0] color;
  logic [7:0]  adr [3] = '{8'h00, 8'h5A, 8'hFF};
  logic [7:0]  ofs [6] = '{OFS_FRAME_TOTAL_HEIGHT, OFS_FRAME_TOTAL_WIDTH, OFS_ACTIVE_AREA_OFFSETS,
                           OFS_HSYNC_CONTROL, OFS_VSYNC_CONTROL, OFS_BLANKING_CONTROL};
  logic [15:0] ctl [3] = '{16'h8000, 16'h8100, 16'h0000};
  logic [15:0] hue [3] = '{16'hFF00, 16'h00FF, 16'h00FF};
  int          failures = 0, checked = 0, cycles = 0, per, hi, lead;

  always #2.5 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      end_of_test();
    end
  end

  display_timing_and_palette_port display_timing_and_palette_port_inst (
    .i_sys_clk(clk), .i_rst(rst), .i_pixel_clock(pclk), .i_pixel_index(idx),
    .o_panel_clock(pc), .o_hsync(hs), .o_vsync(vs), .o_display_enable(de),
    .o_active_area(aa), .o_pixel_color(color), .o_panel_power(pwr),
    .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid), .o_axi_awready(awready),
    .i_axi_wdata(wdata), .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
    .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
    .i_axi_araddr(araddr), .i_axi_arvalid(arvalid), .o_axi_arready(arready),
    .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready));
  panel_model panel_model_inst (.i_run(run), .o_pixel_clock(pclk));

  task automatic end_of_test();
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check

  // Address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [3:0] s,
                    input logic [1:0] er = RESP_OKAY);
    awaddr <= a;
    wdata <= {16'h0000, v};
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    check(bresp, er);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk); while (rvalid !== 1'h1);
    check(rdata, exp);
    check(rresp, er);
  endtask : rd

  function automatic logic pick(input int k);
    case (k)
      0: return hs;
      1: return vs;
      2: return de;
      default: return aa;
    endcase
  endfunction : pick

  // Step to the next panel clock rise
  task automatic sample();
    logic p;
    do begin
      p = pc;
      @(posedge clk);
    end while (!(pc === 1'h1 && p === 1'h0));
  endtask : sample

  // Period of t in pixels; highs and first high of s
  task automatic measure(input int t, input int s);
    logic pt;
    per = 0;
    hi = 0;
    lead = -1;
    do begin
      pt = pick(t);
      sample();
    end while (!(pick(t) === 1'h1 && pt === 1'h0));
    do begin
      if (pick(s) === 1'h1 && lead < 0) lead = per;
      hi += int'(pick(s) === 1'h1);
      per++;
      pt = pick(t);
      sample();
    end while (!(pick(t) === 1'h1 && pt === 1'h0));
  endtask : measure

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    for (int a = 0; a <= 'h24; a += 4) rd(8'(a), 32'h0);
    rd(8'h28, 32'h0, RESP_SLVERR);
    wr(8'h28, 16'hFFFF, 4'h3, RESP_SLVERR);
    wr(OFS_PALETTE_READ_DATA, 16'hFFFF, 4'h3);
    rd(OFS_PALETTE_READ_DATA, 32'h0);
    foreach (ofs[i]) begin
      wr(ofs[i], 16'hA5C3, 4'h3);
      rd(ofs[i], i < 2 ? 32'h0000_05C3 : 32'h0000_A5C3);
    end
    // Busy is over before a read can look
    wr(OFS_PALETTE_CONTROL, 16'hFFFF, 4'h3);
    rd(OFS_PALETTE_CONTROL, 32'h0000_83FF);
    // Load three entries, read each back
    foreach (adr[i]) begin
      wr(OFS_PALETTE_CONTROL, {8'h01, adr[i]}, 4'h3);
      wr(OFS_PALETTE_WRITE_DATA, {adr[i], ~adr[i]}, 4'h3);
    end
    foreach (adr[i]) begin
      wr(OFS_PALETTE_CONTROL, {8'h01, adr[i]}, 4'h3);
      wr(OFS_PALETTE_CONTROL, {8'h03, adr[i]}, 4'h3);
      rd(OFS_PALETTE_READ_DATA, {16'h0000, adr[i], ~adr[i]});
    end
    wr(OFS_PALETTE_CONTROL, 16'h015A, 4'h3);
    wr(OFS_PALETTE_WRITE_DATA, 16'h1277, 4'h1);
    rd(OFS_PALETTE_WRITE_DATA, 32'h0000_FF77);
    wr(OFS_PALETTE_CONTROL, 16'h035A, 4'h3);
    rd(OFS_PALETTE_READ_DATA, 32'h0000_5AA5);
    // No table access without access enable
    wr(OFS_PALETTE_CONTROL, 16'h0000, 4'h3);
    wr(OFS_PALETTE_WRITE_DATA, 16'h1234, 4'h3);
    wr(OFS_PALETTE_CONTROL, 16'h0200, 4'h3);
    rd(OFS_PALETTE_READ_DATA, 32'h0000_5AA5);
    wr(OFS_PALETTE_CONTROL, 16'h0100, 4'h3);
    wr(OFS_PALETTE_CONTROL, 16'h0300, 4'h3);
    rd(OFS_PALETTE_READ_DATA, 32'h0000_00FF);
    idx <= 8'hFF;
    foreach (ctl[i]) begin
      wr(OFS_PALETTE_CONTROL, ctl[i], 4'h3);
      repeat (2) @(posedge clk);
      check(color, hue[i]);
    end
    // Frame of four pixels by three lines
    wr(OFS_FRAME_TOTAL_WIDTH, 16'h0004, 4'h3);
    wr(OFS_FRAME_TOTAL_HEIGHT, 16'h0003, 4'h3);
    wr(OFS_HSYNC_CONTROL, 16'h0201, 4'h3);
    wr(OFS_VSYNC_CONTROL, 16'h0101, 4'h3);
    wr(OFS_BLANKING_CONTROL, 16'h0102, 4'h3);
    wr(OFS_ACTIVE_AREA_OFFSETS, 16'h0203, 4'h3);
    wr(OFS_DISPLAY_CONTROL, 16'h0000, 4'h3);
    run <= 1'h1;
    seen = 1'h0;
    repeat (200) begin
      @(posedge clk);
      seen = seen | hs | vs;
    end
    check(seen, 0);
    for (int m = 1; m <= 4; m++) begin
      wr(OFS_DISPLAY_CONTROL, 16'(m << 4) | 16'h0003, 4'h3);
      rd(OFS_DISPLAY_CONTROL, 32'(m << 4) | 32'h3);
    end
    measure(0, 0);
    check(per, 4);
    check(hi, 2);
    measure(1, 1);
    check(per, 12);
    check(hi, 4);
    measure(1, 0);
    check(lead, 1);
    measure(1, 2);
    check(lead, 2);
    check(hi, 4);
    measure(1, 3);
    check(lead, 7);
    measure(3, 1);
    check(lead, 5);
    // Power-up waits three line ends
    wr(OFS_PALETTE_WRITE_DATA, 16'h0003, 4'h3);
    wr(OFS_DISPLAY_CONTROL, 16'h0047, 4'h3);
    per = 0;
    while (pwr !== 1'h1 && per < 40) begin
      sample();
      per++;
    end
    check(per >= 8 && per <= 13, 1);
    wr(OFS_PALETTE_WRITE_DATA, 16'h0000, 4'h3);
    wr(OFS_DISPLAY_CONTROL, 16'h0043, 4'h3);
    repeat (2) @(posedge clk);
    check(pwr, 0);
    end_of_test();
  end
endmodule : tb

bind display_timing_and_palette_port display_timing_checker display_timing_checker_inst (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_pixel_clock(i_pixel_clock),
  .o_panel_clock(o_panel_clock), .o_hsync(o_hsync), .o_vsync(o_vsync),
  .o_panel_power(o_panel_power), .i_axi_awvalid(i_axi_awvalid), .o_axi_awready(o_axi_awready),
  .i_axi_wvalid(i_axi_wvalid), .o_axi_wready(o_axi_wready), .o_axi_bvalid(o_axi_bvalid),
  .i_axi_bready(i_axi_bready), .i_axi_arvalid(i_axi_arvalid), .o_axi_arready(o_axi_arready),
  .o_axi_rdata(o_axi_rdata), .o_axi_rresp(o_axi_rresp), .o_axi_rvalid(o_axi_rvalid),
  .i_axi_rready(i_axi_rready));
`default_nettype wire
